// *** hms_adc_model.sv ***
`timescale 1ns/10ps
module hms_adc_model
  import hms_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire hms_adc_req_t req_i,
  input wire logic [ADC_W-1:0] level_i,
  input wire logic slow_i,
  output logic done_o,
  output logic [ADC_W-1:0] data_o
);
  int cnt;
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    // result valid only with done; garbage otherwise
    data_o <= ~data_o;
    if (rst_i) begin
      cnt <= 0;
      data_o <= '0;
    end else if (req_i.start) begin
      cnt <= slow_i ? 9 : 2;
    end else if (cnt == 1) begin
      done_o <= 1'b1;
      data_o <= level_i;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule // hms_adc_model

// *** hms_chk_monitor.sv ***
`timescale 1ns/10ps
module hms_chk_monitor
  import hms_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire hms_adc_req_t adc_req_o,
  input wire logic adc_done_i,
  input wire logic irq_o,
  input wire logic int_n_o,
  input wire logic int_oe_o
);
  logic pending;
  // conversion in flight, seen only from the ports
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending <= 1'b0;
    end else if (adc_req_o.start) begin
      pending <= 1'b1;
    end else if (adc_done_i) begin
      pending <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_start_pulse: assert property (adc_req_o.start |=> !adc_req_o.start)
    else $error("start wider than one cycle");
  a_chan_range: assert property (adc_req_o.start |-> adc_req_o.chan <= CH_LAST)
    else $error("channel out of range");
  a_chan_hold: assert property (pending |-> $stable(adc_req_o.chan) && !adc_req_o.start)
    else $error("channel moved during conversion");
  a_pin_gate: assert property (int_oe_o |-> irq_o && !int_n_o)
    else $error("pin driven without pending source");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && !irq_o && !int_oe_o && !adc_req_o.start)
    else $error("outputs active after reset");
endmodule // hms_chk_monitor

bind hms_monitor hms_chk_monitor i_hms_chk_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .adc_req_o(adc_req_o), .adc_done_i(adc_done_i),
  .irq_o(irq_o), .int_n_o(int_n_o), .int_oe_o(int_oe_o)
);

// *** hms_fan_counter.sv ***
`timescale 1ns/10ps
module hms_fan_counter
  import hms_pkg::*;
#(
  parameter int TICK_CYCLES = FAN_TICK_CYCLES,
  parameter int CNT_W = FAN_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tach_i,
  input wire logic enable_i,
  input wire logic [1:0] div_i,
  output logic [CNT_W-1:0] count_o,
  output logic valid_o
);

  typedef struct packed {
    logic [13:0] pre;
    logic [CNT_W-1:0] cnt;
    logic prev;
    logic [CNT_W-1:0] count;
    logic valid;
  } hms_fan_st_t;

  hms_fan_st_t s;
  hms_fan_st_t next_s;

  always_comb begin
    logic [13:0] tick_len;
    logic tick;
    tick_len = 14'(TICK_CYCLES) << div_i;
    tick = (s.pre >= tick_len - 14'h0001);
    next_s = s;
    next_s.valid = 1'b0;
    next_s.prev = tach_i;
    if (!enable_i) begin
      next_s.pre = '0;
      next_s.cnt = '0;
    end else if (s.prev && !tach_i) begin
      // one revolution period ends on each falling tach edge
      next_s.count = s.cnt;
      next_s.valid = 1'b1;
      next_s.cnt = '0;
      next_s.pre = '0;
    end else if (tick) begin
      next_s.pre = '0;
      if (&s.cnt) begin
        // stalled fan still reports, as full scale
        next_s.count = s.cnt;
        next_s.valid = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 1'b1;
      end
    end else begin
      next_s.pre = s.pre + 14'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count_o = s.count;
  assign valid_o = s.valid;

endmodule // hms_fan_counter

// *** hms_monitor.sv ***
// How it works
// RULE1: cycle converter through enabled channels repeatedly
// RULE2: fan counters run alongside the converter
// RULE3: results stored in value registers, compared
// RULE4: out-of-limit sets status bit, raises interrupt
// RULE5: mask bit for every status bit
// RULE6: chmode bit 3 selects 3.3/5 V supply
// RULE7: converter results are ten bits wide
// RULE8: dual inputs: analog channel or fan tach
// RULE9: fan divisor suits speed and pulse count
// RULE10: pin pair: two rails or diode two
// RULE11: code bit 4 alone, bits 3..0 shared
// RULE12: each code bit may become interrupt input
// RULE13: on-chip ambient sensor is in sequence
// RULE14: all control only through the register bus
// RULE15: interrupt pin off until config bit 1
// RULE16: status registers mirrored at 4C and 4D
// RULE17: addressed register selected by bus address
// RULE18: reset restores every register default
// RULE19: open-drain interrupt low while unmasked pending
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
module hms_monitor
  import hms_pkg::*;
#(
  parameter int FAN_TICKS = FAN_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output hms_adc_req_t adc_req_o,
  input wire logic adc_done_i,
  input wire logic [ADC_W-1:0] adc_data_i,
  input wire logic tach_or_analog_in1_i,
  input wire logic tach_or_analog_in2_i,
  input wire logic core_voltage_code_bit0_i,
  input wire logic core_voltage_code_bit1_i,
  input wire logic core_voltage_code_bit2_i,
  input wire logic core_voltage_code_bit3_i,
  input wire logic core_voltage_code_bit4_i,
  output logic irq_o,
  output logic int_n_o,
  output logic int_oe_o
);

  typedef struct packed {
    hms_seq_t seq;
    logic [3:0] ch;
    hms_adc_req_t adc;
    logic [7:0] cfg;
    logic [7:0] chmode;
    logic [3:0] fandiv;
    logic [NUM_VID-1:0] vid_irq_en;
    logic [NUM_CH-1:0][ADC_W-1:0] val;
    logic [NUM_CH-1:0][ADC_W-1:0] lim_hi;
    logic [NUM_CH-1:0][ADC_W-1:0] lim_lo;
    logic [NUM_FAN-1:0][FAN_W-1:0] fan_val;
    logic [NUM_FAN-1:0][FAN_W-1:0] fan_lim;
    logic [ST1_W-1:0] stat1;
    logic [ST2_W-1:0] stat2;
    logic [ST1_W-1:0] mask1;
    logic [ST2_W-1:0] mask2;
    logic [NUM_FAN-1:0] tach_s1;
    logic [NUM_FAN-1:0] tach_s2;
    logic [NUM_VID-1:0] vid_s1;
    logic [NUM_VID-1:0] vid_s2;
    logic [NUM_VID-1:0] vid_prev;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic int_n;
    logic int_oe;
  } hms_st_t;

  hms_st_t s;
  hms_st_t next_s;

  logic [NUM_FAN-1:0][FAN_W-1:0] fan_count;
  logic [NUM_FAN-1:0] fan_valid;

  // channel takes part in the sequence under the current pin modes
  function automatic logic chan_on(input logic [3:0] ch, input logic [7:0] mode);
    logic on;
    on = 1'b1;
    unique case (ch)
      CH_AIN1: on = mode[CHMODE_IN1_ANALOG_BIT]; // RULE8
      CH_AIN2: on = mode[CHMODE_IN2_ANALOG_BIT]; // RULE8
      CH_CORE2, CH_2V5: on = !mode[CHMODE_DIODE2_BIT]; // RULE10
      CH_TEMP_D2: on = mode[CHMODE_DIODE2_BIT]; // RULE10
      default: on = 1'b1;
    endcase
    return on;
  endfunction

  function automatic logic [3:0] next_chan(input logic [3:0] ch, input logic [7:0] mode);
    logic [3:0] c;
    logic found;
    c = ch;
    found = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (!found) begin
        c = (c == CH_LAST) ? 4'h0 : c + 4'h1; // RULE1
        found = chan_on(c, mode);
      end
    end
    return c;
  endfunction

  // index lies within one block of per-channel registers
  function automatic logic in_block(input logic [7:0] idx, input logic [7:0] first,
                                    input logic [7:0] last);
    return idx >= first && idx <= last;
  endfunction

  // fan speed counters, free of the converter sequence
  for (genvar f = 0; f < NUM_FAN; f++) begin : g_fan
    hms_fan_counter #(
      .TICK_CYCLES(FAN_TICKS),
      .CNT_W(FAN_W)
    ) u_fan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tach_i(s.tach_s2[f]),
      .enable_i(!s.chmode[CHMODE_IN1_ANALOG_BIT + f]),
      .div_i(s.fandiv[2*f +: 2]),
      .count_o(fan_count[f]),
      .valid_o(fan_valid[f])
    ); // RULE2 RULE9
  end

  always_comb begin
    logic [7:0] idx;
    logic rd;
    logic wr;
    logic [31:0] rdata;
    logic [ST1_W-1:0] set1;
    logic [ST1_W-1:0] clr1;
    logic [ST2_W-1:0] set2;
    logic [ST2_W-1:0] clr2;
    logic [NUM_VID-1:0] vid_code;
    logic pending;
    idx = wb_adr_i[9:2]; // RULE17
    // one access per request: the cycle with ack up is not taken again
    rd = wb_cyc_i && wb_stb_i && !s.ack && !wb_we_i;
    wr = wb_cyc_i && wb_stb_i && !s.ack && wb_we_i && wb_sel_i[0];
    rdata = 32'h0000_0000;
    set1 = '0;
    clr1 = '0;
    set2 = '0;
    clr2 = '0;
    vid_code = s.vid_s2 & ~s.vid_irq_en; // RULE12
    pending = 1'b0;
    next_s = s;

    // pin synchronisers
    next_s.tach_s1 = {tach_or_analog_in2_i, tach_or_analog_in1_i};
    next_s.tach_s2 = s.tach_s1;
    next_s.vid_s1 = {core_voltage_code_bit4_i, core_voltage_code_bit3_i,
                     core_voltage_code_bit2_i, core_voltage_code_bit1_i,
                     core_voltage_code_bit0_i};
    next_s.vid_s2 = s.vid_s1;
    next_s.vid_prev = s.vid_s2;
    // pins idle high; a falling edge is the request
    set2[ST2_IRQ_LSB +: NUM_VID] = s.vid_prev & ~s.vid_s2 & s.vid_irq_en; // RULE12 RULE4

    // measurement sequence
    // done only counts while waiting; stray pulses are dropped
    next_s.adc.start = 1'b0;
    unique case (s.seq)
      SEQ_IDLE: begin
        if (s.cfg[CFG_START_BIT]) begin
          next_s.ch = next_chan(CH_LAST, s.chmode); // RULE1
          next_s.seq = SEQ_START;
        end
      end
      SEQ_START: begin
        next_s.adc.chan = s.ch; // RULE13
        next_s.adc.vcc_5v = s.chmode[CHMODE_VCC_5V_BIT]; // RULE6
        next_s.adc.diode2 = s.chmode[CHMODE_DIODE2_BIT]; // RULE10
        next_s.adc.start = 1'b1;
        next_s.seq = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (adc_done_i) begin
          next_s.val[s.ch] = adc_data_i; // RULE3 RULE7
          if (adc_data_i > s.lim_hi[s.ch] || adc_data_i < s.lim_lo[s.ch]) begin
            set1[s.ch] = 1'b1; // RULE3 RULE4
          end
          next_s.ch = next_chan(s.ch, s.chmode); // RULE1
          // stopping takes effect at the end of the running conversion
          next_s.seq = s.cfg[CFG_START_BIT] ? SEQ_START : SEQ_IDLE;
        end
      end
    endcase

    // fan results: a count above limit means the fan is too slow
    for (int f = 0; f < NUM_FAN; f++) begin
      if (fan_valid[f]) begin
        next_s.fan_val[f] = fan_count[f]; // RULE2 RULE3
        if (fan_count[f] > s.fan_lim[f]) begin
          set2[ST2_FAN_LSB + f] = 1'b1; // RULE4
        end
      end
    end

    // register reads
    if (in_block(idx, REG_VAL_BASE, REG_VAL_LAST)) begin
      rdata[ADC_W-1:0] = s.val[4'(idx - REG_VAL_BASE)]; // RULE3
    end else if (in_block(idx, REG_LIM_HI_BASE, REG_LIM_HI_LAST)) begin
      rdata[ADC_W-1:0] = s.lim_hi[4'(idx - REG_LIM_HI_BASE)];
    end else if (in_block(idx, REG_LIM_LO_BASE, REG_LIM_LO_LAST)) begin
      rdata[ADC_W-1:0] = s.lim_lo[4'(idx - REG_LIM_LO_BASE)];
    end else begin
      unique case (idx)
        REG_CHMODE: rdata[7:0] = s.chmode;
        REG_CONFIG: rdata[7:0] = s.cfg;
        REG_FAN1_VAL: rdata[FAN_W-1:0] = s.fan_val[0];
        REG_FAN2_VAL: rdata[FAN_W-1:0] = s.fan_val[1];
        REG_FAN1_LIM: rdata[FAN_W-1:0] = s.fan_lim[0];
        REG_FAN2_LIM: rdata[FAN_W-1:0] = s.fan_lim[1];
        REG_STAT1, REG_STAT1_MIRROR: rdata[ST1_W-1:0] = s.stat1; // RULE16
        REG_STAT2, REG_STAT2_MIRROR: rdata[ST2_W-1:0] = s.stat2; // RULE16
        REG_MASK1: rdata[ST1_W-1:0] = s.mask1;
        REG_MASK2: rdata[ST2_W-1:0] = s.mask2;
        REG_FANDIV_VID: rdata[7:0] = {s.fandiv, vid_code[3:0]}; // RULE11
        REG_VID4: rdata[0] = vid_code[4]; // RULE11
        REG_VID_IRQ_EN: rdata[NUM_VID-1:0] = s.vid_irq_en;
        default: rdata = 32'h0000_0000;
      endcase
    end

    // reading a status register clears it
    if (rd && (idx == REG_STAT1 || idx == REG_STAT1_MIRROR)) begin
      clr1 = '1;
    end
    if (rd && (idx == REG_STAT2 || idx == REG_STAT2_MIRROR)) begin
      clr2 = '1;
    end

    // register writes, the only control path
    if (wr) begin // RULE14
      if (in_block(idx, REG_LIM_HI_BASE, REG_LIM_HI_LAST)) begin
        next_s.lim_hi[4'(idx - REG_LIM_HI_BASE)] = wb_dat_i[ADC_W-1:0];
      end else if (in_block(idx, REG_LIM_LO_BASE, REG_LIM_LO_LAST)) begin
        next_s.lim_lo[4'(idx - REG_LIM_LO_BASE)] = wb_dat_i[ADC_W-1:0];
      end else begin
        unique case (idx)
          REG_CHMODE: next_s.chmode = wb_dat_i[7:0];
          REG_CONFIG: next_s.cfg = wb_dat_i[7:0];
          REG_FAN1_LIM: next_s.fan_lim[0] = wb_dat_i[FAN_W-1:0];
          REG_FAN2_LIM: next_s.fan_lim[1] = wb_dat_i[FAN_W-1:0];
          REG_MASK1: next_s.mask1 = wb_dat_i[ST1_W-1:0]; // RULE5
          REG_MASK2: next_s.mask2 = wb_dat_i[ST2_W-1:0]; // RULE5
          REG_FANDIV_VID: next_s.fandiv = wb_dat_i[FANDIV_LSB +: 4]; // RULE9
          REG_VID_IRQ_EN: next_s.vid_irq_en = wb_dat_i[NUM_VID-1:0]; // RULE12
          default: next_s.cfg = s.cfg;
        endcase
      end
    end

    // a new event outweighs a clear in the same cycle
    next_s.stat1 = (s.stat1 & ~clr1) | set1; // RULE4
    next_s.stat2 = (s.stat2 & ~clr2) | set2; // RULE4

    // bus answer one cycle after the request, then dropped
    next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
    next_s.dat = rd ? rdata : s.dat;

    pending = |(next_s.stat1 & ~next_s.mask1) || |(next_s.stat2 & ~next_s.mask2); // RULE5
    next_s.irq = pending; // RULE4
    next_s.int_oe = pending && next_s.cfg[CFG_INT_EN_BIT]; // RULE15 RULE19
    next_s.int_n = !(pending && next_s.cfg[CFG_INT_EN_BIT]); // RULE19
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin // RULE18
      s <= '0;
      s.seq <= SEQ_IDLE;
      s.cfg <= CONFIG_RST;
      s.chmode <= CHMODE_RST;
      s.fandiv <= FANDIV_RST;
      s.lim_hi <= {NUM_CH{LIM_HI_RST}};
      s.lim_lo <= {NUM_CH{LIM_LO_RST}};
      s.fan_lim <= {NUM_FAN{FAN_LIM_RST}};
      s.int_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign adc_req_o = s.adc;
  assign irq_o = s.irq;
  assign int_n_o = s.int_n;
  assign int_oe_o = s.int_oe;

endmodule // hms_monitor

// *** hms_pkg.sv ***
package hms_pkg;

  localparam int NUM_CH = 11;
  localparam int NUM_FAN = 2;
  localparam int NUM_VID = 5;
  localparam int ADC_W = 10;
  localparam int FAN_W = 8;

  // converter channel codes, in sequence order
  localparam logic [3:0] CH_12V = 4'h0;
  localparam logic [3:0] CH_5V = 4'h1;
  localparam logic [3:0] CH_CORE1 = 4'h2;
  localparam logic [3:0] CH_SUPPLY = 4'h3;
  localparam logic [3:0] CH_AIN1 = 4'h4;
  localparam logic [3:0] CH_AIN2 = 4'h5;
  localparam logic [3:0] CH_CORE2 = 4'h6;
  localparam logic [3:0] CH_2V5 = 4'h7;
  localparam logic [3:0] CH_TEMP_D1 = 4'h8;
  localparam logic [3:0] CH_TEMP_D2 = 4'h9;
  localparam logic [3:0] CH_TEMP_INT = 4'hA;
  localparam logic [3:0] CH_LAST = 4'hA;

  // register indices; byte address is four times the index
  localparam logic [7:0] REG_CHMODE = 8'h16;
  localparam logic [7:0] REG_VAL_BASE = 8'h20;
  localparam logic [7:0] REG_VAL_LAST = 8'h2A;
  localparam logic [7:0] REG_FAN1_VAL = 8'h2B;
  localparam logic [7:0] REG_FAN2_VAL = 8'h2C;
  localparam logic [7:0] REG_CONFIG = 8'h40;
  localparam logic [7:0] REG_STAT1 = 8'h41;
  localparam logic [7:0] REG_STAT2 = 8'h42;
  localparam logic [7:0] REG_MASK1 = 8'h43;
  localparam logic [7:0] REG_MASK2 = 8'h44;
  localparam logic [7:0] REG_FANDIV_VID = 8'h47;
  localparam logic [7:0] REG_VID4 = 8'h49;
  localparam logic [7:0] REG_VID_IRQ_EN = 8'h4A;
  localparam logic [7:0] REG_STAT1_MIRROR = 8'h4C;
  localparam logic [7:0] REG_STAT2_MIRROR = 8'h4D;
  localparam logic [7:0] REG_LIM_HI_BASE = 8'h50;
  localparam logic [7:0] REG_LIM_HI_LAST = 8'h5A;
  localparam logic [7:0] REG_FAN1_LIM = 8'h5B;
  localparam logic [7:0] REG_FAN2_LIM = 8'h5C;
  localparam logic [7:0] REG_LIM_LO_BASE = 8'h60;
  localparam logic [7:0] REG_LIM_LO_LAST = 8'h6A;

  // field positions
  localparam int CFG_START_BIT = 0;
  localparam int CFG_INT_EN_BIT = 1;
  localparam int CHMODE_IN1_ANALOG_BIT = 0;
  localparam int CHMODE_IN2_ANALOG_BIT = 1;
  localparam int CHMODE_DIODE2_BIT = 2;
  localparam int CHMODE_VCC_5V_BIT = 3;
  localparam int FANDIV_LSB = 4;
  localparam int ST2_FAN_LSB = 0;
  localparam int ST2_IRQ_LSB = 2;
  localparam int ST1_W = NUM_CH;
  localparam int ST2_W = NUM_FAN + NUM_VID;

  // reset values
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] CHMODE_RST = 8'h00;
  localparam logic [9:0] LIM_HI_RST = 10'h3FF;
  localparam logic [9:0] LIM_LO_RST = 10'h000;
  localparam logic [7:0] FAN_LIM_RST = 8'hFF;
  localparam logic [3:0] FANDIV_RST = 4'h0;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int FAN_TICK_NS = 44400;
  localparam int FAN_TICK_CYCLES = FAN_TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT} hms_seq_t;

  typedef struct packed {
    logic [3:0] chan;
    logic start;
    logic vcc_5v;
    logic diode2;
  } hms_adc_req_t;

endpackage

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top
  import hms_pkg::*;
();
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, t1 = 0, slow = 0, trun = 0;
  logic [9:0] adr = '0, level = 10'h2A5;
  logic [3:0] sel = 4'hF, wsel = 4'hF;
  logic [31:0] dat = '0, rdat, dato;
  logic [4:0] vid = '0;
  logic ack, done, irq, intn, inte;
  logic [ADC_W-1:0] data;
  hms_adc_req_t req;
  logic [3:0] seq[$];
  logic [1:0] mlast;
  logic [3:0] e0[10] = '{0, 1, 2, 3, 6, 7, 8, 10, 0, 0};
  logic [3:0] e1[10] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 0};
  int err_count = 0, checks = 0, cyc_cnt = 0, tc = 0;
  always #20 clk_i = ~clk_i;
  hms_monitor #(.FAN_TICKS(4)) i_hms_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .adc_req_o(req),
    .adc_done_i(done), .adc_data_i(data), .tach_or_analog_in1_i(t1),
    .tach_or_analog_in2_i(t1), .core_voltage_code_bit0_i(vid[0]),
    .core_voltage_code_bit1_i(vid[1]), .core_voltage_code_bit2_i(vid[2]),
    .core_voltage_code_bit3_i(vid[3]), .core_voltage_code_bit4_i(vid[4]),
    .irq_o(irq), .int_n_o(intn), .int_oe_o(inte));
  hms_adc_model i_hms_adc_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .level_i(level), .slow_i(slow), .done_o(done), .data_o(data));
  // tach period 320 ns: toggle every 4 cycles
  always @(posedge clk_i) begin
    if (req.start === 1'b1) begin
      seq.push_back(req.chan);
      mlast <= {req.vcc_5v, req.diode2};
    end
    tc <= tc + 1;
    if (trun && tc % 4 == 3) t1 <= ~t1;
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_count++;
      conclude();
    end
  end
  task conclude;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk_rng(input logic [31:0] g, input int lo, input int hi);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t got %h out of range", $time, g);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task bus(input logic w, input logic [7:0] r, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {r, 2'b00};
    dat <= d;
    sel <= wsel;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dato;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task wr(input logic [7:0] r, input logic [31:0] d);
    bus(1'b1, r, d);
  endtask
  task rdc(input logic [7:0] r, input logic [31:0] e);
    bus(1'b0, r, 0);
    chk(rdat, e);
  endtask
  task s_defaults;
    rdc(REG_CONFIG, 0);
    rdc(REG_CHMODE, 0);
    rdc(REG_MASK1, 0);
    rdc(REG_STAT1, 0);
    rdc(REG_LIM_HI_BASE, 32'h3FF);
    rdc(REG_LIM_LO_LAST, 0);
    rdc(REG_FAN1_LIM, 32'hFF);
    rdc(REG_VID_IRQ_EN, 0);
  endtask
  task s_unmapped;
    rdc(8'h10, 0);
    wr(8'h10, 32'hFF);
    rdc(8'h10, 0);
    wsel = 4'hE;
    wr(REG_MASK1, 32'h7FF);
    wsel = 4'hF;
    rdc(REG_MASK1, 0);
  endtask
  task s_seq(input logic [7:0] m, input int n, input logic [3:0] e[10]);
    wr(REG_CHMODE, {24'h0, m});
    seq.delete();
    wr(REG_CONFIG, 1);
    while (seq.size() <= n) @(posedge clk_i);
    wr(REG_CONFIG, 0);
    idle(30);
    for (int i = 0; i <= n; i++) chk(seq[i], e[i]);
    chk(mlast, m[3:2]);
  endtask
  task s_irq;
    wr(REG_LIM_HI_BASE, 32'h100);
    wr(REG_MASK1, 32'h7FF);
    wr(REG_MASK2, 32'h7F);
    wr(REG_CONFIG, 1);
    idle(60);
    wr(REG_CONFIG, 0);
    idle(30);
    chk(irq, 0);
    rdc(REG_VAL_BASE, {22'h0, level});
    rdc(REG_VAL_LAST, {22'h0, level});
    wr(REG_MASK1, 0);
    wr(REG_MASK2, 0);
    idle(3);
    chk(irq, 1);
    chk(inte, 0);
    wr(REG_CONFIG, 2);
    idle(3);
    chk({inte, intn}, 2'b10);
    rdc(REG_STAT1_MIRROR, 1);
    idle(3);
    chk({irq, inte, intn}, 3'b001);
    rdc(REG_STAT1, 0);
    wr(REG_LIM_HI_BASE, 32'h3FF);
  endtask
  task s_fan;
    wr(REG_CHMODE, 0);
    wr(REG_FAN1_LIM, 0);
    trun <= 1;
    idle(100);
    bus(1'b0, REG_FAN1_VAL, 0);
    chk_rng(rdat, 1, 3);
    bus(1'b0, REG_STAT2, 0);
    chk(rdat[0], 1);
    wr(REG_FANDIV_VID, 32'h10);
    idle(100);
    bus(1'b0, REG_FAN1_VAL, 0);
    chk_rng(rdat, 0, 0);
    rdc(REG_FAN2_VAL, 1);
    trun <= 0;
    idle(2600);
    rdc(REG_FAN1_VAL, 32'hFF);
  endtask
  task s_code;
    vid <= 5'b10110;
    idle(6);
    rdc(REG_FANDIV_VID, 32'h16);
    rdc(REG_VID4, 1);
    wr(REG_VID_IRQ_EN, 1);
    vid[0] <= 1;
    idle(6);
    bus(1'b0, REG_STAT2, 0);
    vid[0] <= 0;
    idle(6);
    bus(1'b0, REG_STAT2_MIRROR, 0);
    chk(rdat[2], 1);
    bus(1'b0, REG_STAT2, 0);
    chk(rdat[6:2], 0);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    s_defaults();
    s_unmapped();
    s_seq(8'h00, 8, e0);
    slow <= 1;
    s_seq(8'h0F, 9, e1);
    slow <= 0;
    s_irq();
    s_fan();
    s_code();
    rst_i <= 1;
    idle(3);
    rst_i <= 0;
    s_defaults();
    conclude();
  end
endmodule // tb_top
